// file: logic/chan_clk_if.sv
// Carrier between the prescaler core and one channel clock selector
`timescale 1ns/10ps
interface chan_clk_if;
    logic [3:0]  prescaled;
    logic [15:0] mode;
    logic        tin;
    logic        count_clk;
    logic        sample_clk;

    modport core (output prescaled, output mode, output tin, input count_clk, input sample_clk);
    modport chan (input prescaled, input mode, input tin, output count_clk, output sample_clk);
endinterface : chan_clk_if

// file: logic/channel_clock_select.sv
// One channel: operation clock select, input edge detector and count clock
`timescale 1ns/10ps
module channel_clock_select #(
    parameter bit EXTRA_CLK = 1'b0
) (
    input  wire logic    clk,
    input  wire logic    rstn,
    chan_clk_if.chan     bus
);

    typedef struct packed {
        logic tin_q;
        logic count_clk;
        logic sample_clk;
    } chan_s;

    chan_s st_r;
    chan_s st_nxt;
    logic  op_tick;
    logic  edge_ok;

    always_comb
    begin
        timer_clk_pkg::edge_e cis;
        logic                 rise;
        logic                 fall;
        cis  = timer_clk_pkg::edge_e'(bus.mode[timer_clk_pkg::CIS_LSB +: 2]);
        rise = bus.tin & ~st_r.tin_q;
        fall = ~bus.tin & st_r.tin_q;
        // Extra clocks exist only on split-capable channels
        case (timer_clk_pkg::op_clk_e'(bus.mode[timer_clk_pkg::CKS_LSB +: 2])) // see RL13
            timer_clk_pkg::OPCLK_A: op_tick = bus.prescaled[0];
            timer_clk_pkg::OPCLK_C: op_tick = EXTRA_CLK ? bus.prescaled[2] : bus.prescaled[0]; // see RL14
            timer_clk_pkg::OPCLK_B: op_tick = bus.prescaled[1];
            default:                op_tick = EXTRA_CLK ? bus.prescaled[3] : bus.prescaled[1]; // see RL14
        endcase
        case (cis)
            timer_clk_pkg::EDGE_FALL: edge_ok = fall;
            timer_clk_pkg::EDGE_RISE: edge_ok = rise;
            default:                  edge_ok = rise | fall;
        endcase
        st_nxt            = st_r;
        st_nxt.sample_clk = op_tick; // see RL15
        if (op_tick)
            st_nxt.tin_q = bus.tin;
        // Pin edges are only seen on operation clock ticks
        if (bus.mode[timer_clk_pkg::CCS_BIT]) // see RL16
            st_nxt.count_clk = op_tick & edge_ok;
        else
            st_nxt.count_clk = op_tick;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign bus.count_clk  = st_r.count_clk; // see RL18
    assign bus.sample_clk = st_r.sample_clk;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_INTERNAL_COUNT: assert property ( // see RL16
        (!bus.mode[timer_clk_pkg::CCS_BIT] && op_tick) |=> st_r.count_clk)
        else $error("count clock missed an operation clock tick");

    AST_EDGE_NEEDS_TICK: assert property ( // see RL15
        (st_r.count_clk && $past(bus.mode[timer_clk_pkg::CCS_BIT])) |-> $past(op_tick) && $past(edge_ok))
        else $error("edge count without operation tick and valid edge");

    AST_OPCLK_A: assert property ( // see RL13
        (bus.mode[timer_clk_pkg::CKS_LSB +: 2] == 2'h0) |=> (st_r.sample_clk == $past(bus.prescaled[0])))
        else $error("operation clock select 00 does not follow clock a");

endmodule : channel_clock_select

// file: logic/timer_clk_pkg.sv
// Shared constants and types of the timer prescaler and channel clock select
package timer_clk_pkg;

    localparam int          IDX_LSB      = 2;
    localparam int          IDX_W        = 22;
    localparam int          CNT_W        = 15;
    localparam int          NUM_CH       = 8;
    localparam int          NUM_ALT      = 4;

    localparam logic [21:0] PRESC_IDX    = 22'h0F01B6;
    localparam logic [21:0] CHMODE_IDX   = 22'h0F0190;
    localparam logic [21:0] ROUTE_IDX    = 22'h0F0198;
    localparam logic [21:0] CNT_IDX      = 22'h0F0199;

    localparam logic [15:0] PRESC_RST    = 16'h0000;
    localparam logic [15:0] PRESC_WMASK  = 16'h33FF;
    localparam logic [15:0] CHMODE_RST   = 16'h0000;
    localparam logic [15:0] MASK_SPLIT   = 16'hDFCF;
    localparam logic [15:0] MASK_MASTER  = 16'h9FCF;
    localparam logic [15:0] MASK_FIXED   = 16'h97CF;
    localparam logic [7:0]  SPLIT_CH     = 8'h0A;
    localparam logic [7:0]  MASTER_CH    = 8'h54;
    localparam logic [1:0]  ROUTE_RST    = 2'h0;
    localparam logic [1:0]  BE_WORD      = 2'h3;
    localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;
    localparam logic [31:0] RD_ZERO      = 32'h0000_0000;

    localparam int          A_LSB        = 0;
    localparam int          B_LSB        = 4;
    localparam int          C_LSB        = 8;
    localparam int          D_LSB        = 12;
    localparam int          CKS_LSB      = 14;
    localparam int          CCS_BIT      = 12;
    localparam int          WIDTH_BIT    = 11;
    localparam int          CIS_LSB      = 6;

    // Exponents of two for the two narrow prescaler fields
    localparam logic [3:0][3:0] C_EXP    = {4'h6, 4'h4, 4'h2, 4'h1};
    localparam logic [3:0][3:0] D_EXP    = {4'hE, 4'hC, 4'hA, 4'h8};

    typedef enum logic [1:0] {OPCLK_A, OPCLK_C, OPCLK_B, OPCLK_D} op_clk_e;
    typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH_LO, EDGE_BOTH_HI} edge_e;

    // High for one cycle in every 2**k; k of zero is high every cycle
    function automatic logic div_tick(logic [CNT_W-1:0] cnt, logic [3:0] k);
        logic [CNT_W-1:0] m;
        m = CNT_W'((32'h1 << k) - 32'h1);
        return &(cnt | ~m);
    endfunction : div_tick

    function automatic logic [15:0] chmode_mask(logic [2:0] ch);
        logic [15:0] m;
        m = MASK_FIXED;
        if (SPLIT_CH[ch])
            m = MASK_SPLIT;
        else if (MASTER_CH[ch])
            m = MASK_MASTER;
        return m;
    endfunction : chmode_mask

endpackage : timer_clk_pkg

// file: logic/timer_clock_select.sv
// Timer prescaler, channel mode registers and Avalon-MM register slave
// Operation
// RL1: Clock c divides by 2, 4, 16, 64
// RL2: Clock d divides by 256, 1024, 4096, 16384
// RL3: Prescaled clocks are one-cycle enable pulses
// RL4: Software stops channels before clock source change
// RL5: Software keeps prescaler reserved bits zero
// RL6: Prescaler select readable, resets to zero
// RL7: No mode rewrite while channel runs
// RL8: Edge select bits writable while running
// RL9: Mode register written only as 16 bits
// RL10: Mode registers reset to zero
// RL11: Bit 11 is master, split, or fixed
// RL12: Fixed bit 11 reads zero, ignores writes
// RL13: Select 00 a, 01 c, 10 b, 11 d
// RL14: Clocks c and d only on channels 1, 3
// RL15: Operation clock drives the input edge detector
// RL16: Count on operation clock or pin edges
// RL17: Channel 5 pin comes from routing register
// RL18: Count clock feeds counter, output and interrupt
// RL19: Mode register holds mode, trigger, edge fields
// RL20: Clocks a, b divide by 2**field
// RL21: Master bit on channel 2 selects master
// RL22: Split bit on channels 1, 3 selects 8-bit
`timescale 1ns/10ps
module timer_clock_select #(
    parameter int ADDR_W = 24
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic [ADDR_W-1:0]     address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    input  wire logic [7:0]            timer_input_pin,
    input  wire logic [3:0]            alt_timer_input,
    output logic      [3:0]            prescaled_clock,
    output logic      [7:0]            count_clock,
    output logic      [7:0]            sample_clock,
    output logic      [7:0][15:0]      channel_mode
);

    typedef struct packed {
        logic [15:0]                               psel;
        logic [timer_clk_pkg::NUM_CH-1:0][15:0]    chmode;
        logic [1:0]                                route;
        logic [timer_clk_pkg::CNT_W-1:0]           cnt;
        logic [3:0]                                pclk;
        logic                                      waitreq;
        logic [31:0]                               rdata;
    } top_s;

    top_s              st_r;
    top_s              st_nxt;
    logic [21:0]       idx;
    logic              hit_presc;
    logic              hit_chmode;
    logic              hit_route;
    logic              hit_cnt;
    logic [2:0]        ch_sel;
    logic              wr_take;
    logic              word_be;
    logic [7:0]        cnt_clk_w;
    logic [7:0]        smp_clk_w;

    assign idx     = address[timer_clk_pkg::IDX_LSB +: timer_clk_pkg::IDX_W];
    assign ch_sel  = 3'(idx - timer_clk_pkg::CHMODE_IDX);
    assign word_be = (byteenable[1:0] == timer_clk_pkg::BE_WORD);
    // Writes land only on the edge that also sees waitrequest low
    assign wr_take = write && !st_r.waitreq;

    always_comb
    begin
        hit_presc  = 1'b0;
        hit_chmode = 1'b0;
        hit_route  = 1'b0;
        hit_cnt    = 1'b0;
        if (idx == timer_clk_pkg::PRESC_IDX)
            hit_presc = 1'b1;
        else if (idx >= timer_clk_pkg::CHMODE_IDX && idx < timer_clk_pkg::ROUTE_IDX)
            hit_chmode = 1'b1;
        else if (idx == timer_clk_pkg::ROUTE_IDX)
            hit_route = 1'b1;
        else if (idx == timer_clk_pkg::CNT_IDX)
            hit_cnt = 1'b1;
    end

    always_comb
    begin
        logic [3:0] k_a;
        logic [3:0] k_b;
        logic [3:0] k_c;
        logic [3:0] k_d;
        k_a = st_r.psel[timer_clk_pkg::A_LSB +: 4];
        k_b = st_r.psel[timer_clk_pkg::B_LSB +: 4];
        k_c = timer_clk_pkg::C_EXP[st_r.psel[timer_clk_pkg::C_LSB +: 2]];
        k_d = timer_clk_pkg::D_EXP[st_r.psel[timer_clk_pkg::D_LSB +: 2]];
        st_nxt     = st_r;
        st_nxt.cnt = st_r.cnt + 1'b1;
        // One shared counter keeps all four clocks phase aligned
        st_nxt.pclk[0] = timer_clk_pkg::div_tick(st_r.cnt, k_a); // see RL20 RL3
        st_nxt.pclk[1] = timer_clk_pkg::div_tick(st_r.cnt, k_b); // see RL20 RL3
        st_nxt.pclk[2] = timer_clk_pkg::div_tick(st_r.cnt, k_c); // see RL1 RL3
        st_nxt.pclk[3] = timer_clk_pkg::div_tick(st_r.cnt, k_d); // see RL2 RL3

        // One wait state per access, then a single cycle of answer
        if (!st_r.waitreq)
            st_nxt.waitreq = 1'b1;
        else if (read || write)
            st_nxt.waitreq = 1'b0;

        if (read && st_r.waitreq)
        begin
            st_nxt.rdata = timer_clk_pkg::RD_UNMAPPED;
            if (hit_presc)
                st_nxt.rdata = {16'h0000, st_r.psel}; // see RL6
            else if (hit_chmode)
                st_nxt.rdata = {16'h0000, st_r.chmode[ch_sel]}; // see RL19
            else if (hit_route)
                st_nxt.rdata = {30'h0000_0000, st_r.route};
            else if (hit_cnt)
                st_nxt.rdata = {17'h0_0000, st_r.cnt};
        end
        else if (!read)
        begin
            st_nxt.rdata = timer_clk_pkg::RD_ZERO;
        end

        if (wr_take)
        begin
            if (hit_presc && word_be)
                st_nxt.psel = writedata[15:0] & timer_clk_pkg::PRESC_WMASK;
            else if (hit_chmode && word_be) // see RL9
                // Bit 11 role and extra clock reach come from the channel number
                st_nxt.chmode[ch_sel] = writedata[15:0] & timer_clk_pkg::chmode_mask(ch_sel); // see RL8 RL11 RL12 RL14
            else if (hit_route)
                st_nxt.route = writedata[1:0];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r         <= '0;
            st_r.psel    <= timer_clk_pkg::PRESC_RST; // see RL6
            st_r.chmode  <= {timer_clk_pkg::NUM_CH{timer_clk_pkg::CHMODE_RST}}; // see RL10
            st_r.route   <= timer_clk_pkg::ROUTE_RST;
            st_r.waitreq <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    genvar g;
    generate
        for (g = 0; g < timer_clk_pkg::NUM_CH; g++)
        begin : g_ch
            chan_clk_if cif ();
            assign cif.prescaled = st_r.pclk;
            assign cif.mode      = st_r.chmode[g];
            if (g == 5)
            begin : g_routed
                assign cif.tin = alt_timer_input[st_r.route]; // see RL17
            end
            else
            begin : g_pin
                assign cif.tin = timer_input_pin[g];
            end
            channel_clock_select #(
                .EXTRA_CLK (timer_clk_pkg::SPLIT_CH[g])
            ) u_chan (
                .clk  (clk),
                .rstn (rstn),
                .bus  (cif.chan)
            );
            assign cnt_clk_w[g] = cif.count_clk;
            assign smp_clk_w[g] = cif.sample_clk;
        end
    endgenerate

    assign readdata        = st_r.rdata;
    assign waitrequest     = st_r.waitreq;
    assign prescaled_clock = st_r.pclk;
    assign count_clock     = cnt_clk_w; // see RL18
    assign sample_clock    = smp_clk_w;
    // Bit 11 carries master select on 2, 4, 6 and split on 1, 3
    assign channel_mode    = st_r.chmode; // see RL21 RL22

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence s_presc_read;
        read && st_r.waitreq && hit_presc;
    endsequence

    sequence s_half_write(int n);
        write && !st_r.waitreq && idx == timer_clk_pkg::CHMODE_IDX + 22'(n) && !word_be;
    endsequence

    sequence s_full_write(int n);
        write && !st_r.waitreq && idx == timer_clk_pkg::CHMODE_IDX + 22'(n) && word_be;
    endsequence

    AST_PRESC_READBACK: assert property ( // see RL6
        s_presc_read |=> !waitrequest && readdata == {16'h0000, $past(st_r.psel)})
        else $error("prescaler select readback wrong");

    AST_PULSE_ONE_CYCLE: assert property ( // see RL3
        prescaled_clock[2] |=> !prescaled_clock[2])
        else $error("clock c pulse longer than one cycle");

    AST_CLK_C_DIV2: assert property ( // see RL1
        (st_r.psel[timer_clk_pkg::C_LSB +: 2] == 2'h0 && prescaled_clock[2])
        ##1 (st_r.psel[timer_clk_pkg::C_LSB +: 2] == 2'h0) |=> prescaled_clock[2])
        else $error("clock c at divide by two skipped a pulse");

    AST_CLK_D_ALIGN: assert property ( // see RL2
        prescaled_clock[3] |-> $past(st_r.cnt[7:0]) == 8'hFF)
        else $error("clock d pulse off its divide boundary");

    AST_CLK_A_UNDIV: assert property ( // see RL20
        (st_r.psel[timer_clk_pkg::A_LSB +: 4] == 4'h0)[*3] |-> prescaled_clock[0])
        else $error("undivided clock a not high every cycle");

    AST_HALF_WRITE_IGNORED: assert property ( // see RL9
        s_half_write(1) |=> $stable(st_r.chmode[1]))
        else $error("partial write changed a mode register");

    AST_EDGE_BITS_WRITE: assert property ( // see RL8
        s_full_write(2) |=> st_r.chmode[2][timer_clk_pkg::CIS_LSB +: 2] == $past(writedata[7:6]))
        else $error("edge select bits not updated");

    AST_FIXED_BIT11: assert property ( // see RL12
        !st_r.chmode[0][timer_clk_pkg::WIDTH_BIT] && !st_r.chmode[5][timer_clk_pkg::WIDTH_BIT]
        && !st_r.chmode[7][timer_clk_pkg::WIDTH_BIT])
        else $error("fixed bit 11 reads one");

    AST_SPLIT_BIT_KEPT: assert property ( // see RL11
        s_full_write(3) |=> st_r.chmode[3][timer_clk_pkg::WIDTH_BIT] == $past(writedata[11]))
        else $error("split bit not stored on channel 3");

    sequence s_presc_half;
        write && !st_r.waitreq && hit_presc && !word_be;
    endsequence

    sequence s_mode_read;
        read && st_r.waitreq && hit_chmode;
    endsequence

    AST_CLK_C_ALIGN: assert property ( // see RL1
        prescaled_clock[2] |-> $past(st_r.cnt[0]))
        else $error("clock c pulse off its divide boundary");

    AST_CLK_B_ALIGN: assert property ( // see RL20
        (prescaled_clock[1] && $past(st_r.psel[timer_clk_pkg::B_LSB +: 4]) == 4'h9)
        |-> $past(st_r.cnt[8:0]) == 9'h1FF)
        else $error("clock b pulse off its divide boundary");

    AST_CLK_D_PULSE: assert property ( // see RL3
        prescaled_clock[3] |=> !prescaled_clock[3])
        else $error("clock d pulse longer than one cycle");

    AST_PRESC_HALF_IGNORED: assert property ( // see RL6
        s_presc_half |=> $stable(st_r.psel))
        else $error("partial write changed the prescaler select");

    AST_MODE_READBACK: assert property ( // see RL19
        s_mode_read |=> !waitrequest && readdata == {16'h0000, $past(st_r.chmode[ch_sel])})
        else $error("mode register readback wrong");

    AST_MODE_WRITE_LANDS: assert property ( // see RL11
        s_full_write(4) |=> st_r.chmode[4] == ($past(writedata[15:0]) & timer_clk_pkg::MASK_MASTER))
        else $error("mode write on channel 4 not stored as masked");

    AST_MASTER_BIT_KEPT: assert property ( // see RL21
        s_full_write(2) |=> st_r.chmode[2][timer_clk_pkg::WIDTH_BIT] == $past(writedata[11]))
        else $error("master bit not stored on channel 2");

    AST_SPLIT_BIT_CH1: assert property ( // see RL22
        s_full_write(1) |=> st_r.chmode[1][timer_clk_pkg::WIDTH_BIT] == $past(writedata[11]))
        else $error("split bit not stored on channel 1");

    AST_FIXED_WRITE_DROP: assert property ( // see RL12
        s_full_write(7) |=> !st_r.chmode[7][timer_clk_pkg::WIDTH_BIT])
        else $error("write reached fixed bit 11 on channel 7");

    AST_EXTRA_CLK_MASK: assert property ( // see RL14
        !st_r.chmode[0][timer_clk_pkg::CKS_LSB] && !st_r.chmode[2][timer_clk_pkg::CKS_LSB]
        && !st_r.chmode[4][timer_clk_pkg::CKS_LSB] && !st_r.chmode[5][timer_clk_pkg::CKS_LSB]
        && !st_r.chmode[6][timer_clk_pkg::CKS_LSB] && !st_r.chmode[7][timer_clk_pkg::CKS_LSB])
        else $error("clocks c or d selectable outside channels 1 and 3");

    AST_READ_IDLE_ZERO: assert property (
        !read |=> readdata == timer_clk_pkg::RD_ZERO)
        else $error("read data not zero outside a read answer");

    AST_WAIT_ONE_CYCLE: assert property (
        !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

endmodule : timer_clock_select

// file: tb/timer_clock_select_test.sv
// Self-checking bench for the timer prescaler and channel clock select
`timescale 1ns/10ps
module timer_clock_select_test;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    logic [23:0]      address = 24'h000000;
    logic             read = 1'b0;
    logic             write = 1'b0;
    logic [31:0]      writedata = 32'h00000000;
    logic [3:0]       byteenable = 4'h0;
    logic [31:0]      readdata;
    logic             waitrequest;
    logic [7:0]       timer_input_pin = 8'h00;
    logic [3:0]       alt_timer_input = 4'h0;
    logic [3:0]       prescaled_clock;
    logic [7:0]       count_clock;
    logic [7:0]       sample_clock;
    logic [7:0][15:0] channel_mode;
    logic [31:0]      rd;
    int               errors = 0;
    int               compares = 0;

    always #20 clk = ~clk;

    timer_clock_select timer_clock_select_i (
        .clk             (clk),
        .rstn            (rstn),
        .address         (address),
        .read            (read),
        .write           (write),
        .writedata       (writedata),
        .byteenable      (byteenable),
        .readdata        (readdata),
        .waitrequest     (waitrequest),
        .timer_input_pin (timer_input_pin),
        .alt_timer_input (alt_timer_input),
        .prescaled_clock (prescaled_clock),
        .count_clock     (count_clock),
        .sample_clock    (sample_clock),
        .channel_mode    (channel_mode)
    );

    task automatic wrap_up;
        if (errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : check

    task automatic give_up(input string name);
        $display("MISMATCH %s expected done seen timeout", name);
        errors++;
        wrap_up();
    endtask : give_up

    // One Avalon access; the request stands until waitrequest is sampled low
    task automatic access(input logic wr, input logic [21:0] idx, input logic [31:0] wd, input logic [3:0] be);
        int n;
        @(posedge clk);
        address <= {idx, 2'b00};
        read <= ~wr;
        write <= wr;
        writedata <= wd;
        byteenable <= be;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0)
            give_up("waitrequest");
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : access

    task automatic rd_chk(input string name, input logic [21:0] idx, input logic [31:0] exp);
        access(1'b0, idx, 32'h00000000, 4'hF);
        check(name, exp, rd);
    endtask : rd_chk

    function automatic logic [21:0] mode_idx(input int ch);
        return timer_clk_pkg::CHMODE_IDX + 22'(ch);
    endfunction : mode_idx

    // Bit 14 only where the extra clocks exist, bit 11 only where it has a function
    function automatic logic [31:0] mode_mask(input int ch);
        logic [31:0] m;
        m = 32'h0000DFCF;
        if (ch != 1 && ch != 3)
            m[14] = 1'b0;
        if (ch == 0 || ch == 5 || ch == 7)
            m[11] = 1'b0;
        return m;
    endfunction : mode_mask

    task automatic reset_dut;
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
    endtask : reset_dut

    task automatic reset_values;
        rd_chk("prescaler", timer_clk_pkg::PRESC_IDX, 32'h00000000);
        for (int ch = 0; ch < 8; ch++)
            rd_chk("mode", mode_idx(ch), 32'h00000000);
        rd_chk("route", timer_clk_pkg::ROUTE_IDX, 32'h00000000);
        rd_chk("unmapped", 22'h0F0000, 32'h00000000);
    endtask : reset_values

    task automatic prescaler_masking;
        access(1'b1, timer_clk_pkg::PRESC_IDX, 32'h000033FF, 4'hF);
        rd_chk("prescaler", timer_clk_pkg::PRESC_IDX, 32'h000033FF);
        access(1'b1, timer_clk_pkg::PRESC_IDX, 32'h00000000, 4'h1);
        access(1'b1, 22'h0F0000, 32'h00000000, 4'hF);
        rd_chk("prescaler", timer_clk_pkg::PRESC_IDX, 32'h000033FF);
    endtask : prescaler_masking

    task automatic mode_masking;
        for (int ch = 0; ch < 8; ch++)
        begin
            access(1'b1, mode_idx(ch), 32'h0000FFFF, 4'hF);
            rd_chk("mode", mode_idx(ch), mode_mask(ch));
            check("mode port", mode_mask(ch), channel_mode[ch]);
            access(1'b1, mode_idx(ch), 32'h00000000, 4'h2);
            rd_chk("mode", mode_idx(ch), mode_mask(ch));
        end
        // Second reset in mid-run must clear every channel
        reset_dut();
        for (int ch = 0; ch < 8; ch++)
            check("mode port", 32'h00000000, channel_mode[ch]);
    endtask : mode_masking

    task automatic measure(input int b, input int per);
        int n;
        repeat (2) @(negedge clk);
        n = 0;
        while (prescaled_clock[b] !== 1'b1 && n < 40000)
        begin
            @(negedge clk);
            n++;
        end
        if (n >= 40000)
            give_up("pulse");
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
            if (n == 1 && per > 1)
                check("pulse width", 32'h00000000, prescaled_clock[b]);
        end
        while (prescaled_clock[b] !== 1'b1 && n < 40000);
        check("period", per, n);
    endtask : measure

    task automatic prescaler_rates;
        int c_per[4] = '{2, 4, 16, 64};
        int d_per[4] = '{256, 1024, 4096, 16384};
        for (int k = 0; k < 5; k++)
        begin
            access(1'b1, timer_clk_pkg::PRESC_IDX, 32'(k), 4'hF);
            measure(0, 1 << k);
        end
        access(1'b1, timer_clk_pkg::PRESC_IDX, 32'h00000090, 4'hF);
        measure(1, 512);
        for (int k = 0; k < 4; k++)
        begin
            access(1'b1, timer_clk_pkg::PRESC_IDX, 32'(k) << 8, 4'hF);
            measure(2, c_per[k]);
            access(1'b1, timer_clk_pkg::PRESC_IDX, 32'(k) << 12, 4'hF);
            measure(3, d_per[k]);
        end
    endtask : prescaler_rates

    // Channel pulses trail the chosen prescaled pulse by one cycle
    task automatic follow(input int ch, input int s);
        logic prev;
        repeat (3) @(negedge clk);
        prev = prescaled_clock[s];
        repeat (300)
        begin
            @(negedge clk);
            check("sample clock", prev, sample_clock[ch]);
            check("count clock", prev, count_clock[ch]);
            prev = prescaled_clock[s];
        end
    endtask : follow

    task automatic follow_select;
        int sel[4] = '{0, 2, 1, 3};
        access(1'b1, timer_clk_pkg::PRESC_IDX, 32'h00000231, 4'hF);
        for (int cks = 0; cks < 4; cks++)
        begin
            access(1'b1, mode_idx(1), 32'(cks) << 14, 4'hF);
            follow(1, sel[cks]);
        end
        access(1'b1, mode_idx(0), 32'h00004000, 4'hF);
        follow(0, 0);
    endtask : follow_select

    // Five high pulses on the chosen input, then quiet time to collect
    task automatic edge_count(input int ch, input int alt, input int exp);
        int n;
        n = 0;
        // Let the last pulse of the previous mode drain before counting
        @(posedge clk);
        for (int i = 0; i < 60; i++)
        begin
            @(posedge clk);
            if (alt < 0)
                timer_input_pin[ch] <= (i < 40) && (i % 8 >= 4);
            else
                alt_timer_input[alt] <= (i < 40) && (i % 8 >= 4);
            if (count_clock[ch] === 1'b1)
                n++;
        end
        check("edge count", exp, n);
    endtask : edge_count

    task automatic edge_modes;
        int e_exp[4] = '{5, 5, 10, 10};
        // Clock a runs undivided while the prescaler select is cleared here, so pin edges are sampled every cycle
        access(1'b1, timer_clk_pkg::PRESC_IDX, 32'h00000000, 4'hF);
        for (int e = 0; e < 4; e++)
        begin
            access(1'b1, mode_idx(2), 32'h00001000 | (32'(e) << 6), 4'hF);
            edge_count(2, -1, e_exp[e]);
        end
        access(1'b1, timer_clk_pkg::ROUTE_IDX, 32'h00000002, 4'hF);
        rd_chk("route", timer_clk_pkg::ROUTE_IDX, 32'h00000002);
        access(1'b1, mode_idx(5), 32'h00001040, 4'hF);
        edge_count(5, 2, 5);
        edge_count(5, -1, 0);
        access(1'b1, timer_clk_pkg::ROUTE_IDX, 32'h00000001, 4'hF);
        edge_count(5, 2, 0);
    endtask : edge_modes

    initial
    begin
        reset_dut();
        reset_values();
        prescaler_masking();
        mode_masking();
        prescaler_rates();
        follow_select();
        edge_modes();
        wrap_up();
    end
endmodule : timer_clock_select_test
